// >>> dadc_chan.sv
// one converter channel: sample clock pickup, six-deep pipeline, format and power state
`timescale 1ns/1ps
module dadc_chan
  import dadc_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // channel pins
  input  wire logic        i_sample_clock,
  input  wire logic [13:0] i_conv_code,
  input  wire logic        i_conv_over,
  // control
  input  wire logic        i_power_down_select,
  input  wire logic        i_output_enable_n,
  input  wire logic        i_twos,
  // result
  output dadc_word_s       o_res,
  output logic             o_res_stb,
  output logic             o_drive,
  output logic             o_clk_lvl,
  output dadc_pwr_e        o_pwr
);

  // ****************************************************************
  // sample clock pickup
  // ****************************************************************
  logic       clk_s1_q;
  logic       clk_s2_q;
  logic       clk_s3_q;
  logic       rise_w;
  logic       convert_w;
  dadc_pwr_e  pwr_w;
  dadc_word_s pipe_q [0:PIPE_LAT-1];
  dadc_word_s res_q;
  dadc_word_s res_d;
  logic       stb_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
    end else begin
      clk_s1_q <= i_sample_clock;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
    end
  end

  // sample instant is the low-to-high transition only
  assign rise_w = clk_s2_q & ~clk_s3_q; // R1 R14

  // ****************************************************************
  // power state
  // ****************************************************************
  assign pwr_w = i_power_down_select ? (i_output_enable_n ? DADC_SLEEP : DADC_NAP) // R7 R8
                                     : (i_output_enable_n ? DADC_RUN_HIZ : DADC_RUN); // R5 R6
  assign convert_w = ~i_power_down_select; // R5 R6
  assign o_drive   = (pwr_w == DADC_RUN); // R5 R6 R7 R8

  // ****************************************************************
  // pipeline
  // ****************************************************************
  // sleep empties the pipe, nap only freezes it
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < PIPE_LAT; i++) begin
        pipe_q[i] <= '0;
      end
    end else if (pwr_w == DADC_SLEEP) begin
      for (int i = 0; i < PIPE_LAT; i++) begin
        pipe_q[i] <= '0;
      end
    end else if (rise_w && convert_w) begin
      pipe_q[0] <= '{over: i_conv_over, data: i_conv_code}; // R11 R14
      for (int i = 1; i < PIPE_LAT; i++) begin
        pipe_q[i] <= pipe_q[i-1]; // R13
      end
    end
  end

  // sixth edge after capture moves the word out
  assign res_d = '{over: pipe_q[PIPE_LAT-1].over,
                   data: pipe_q[PIPE_LAT-1].data ^ (i_twos ? TWOS_FLIP : 14'h0000)}; // R9 R12

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      res_q <= '0;
      stb_q <= 1'b0;
    end else begin
      stb_q <= rise_w & convert_w;
      if (rise_w && convert_w) begin
        res_q <= res_d; // R13 R15
      end
    end
  end

  assign o_res     = res_q;
  assign o_res_stb = stb_q;
  assign o_clk_lvl = clk_s2_q;
  assign o_pwr     = pwr_w;

endmodule

// >>> dadc_conv_model.sv
// converter front end model: sample clock frames and codes
`timescale 1ns/1ps
module dadc_conv_model #(
  parameter int HALF = 4
) (
  // clock and reset
  input  logic        i_ref_clk,
  input  logic        i_rst_b,
  // frame request
  input  logic        i_start,
  input  logic [7:0]  i_edges,
  input  logic [13:0] i_base,
  input  logic        i_over,
  // converter side
  output logic        o_sample_clock,
  output logic [13:0] o_code,
  output logic        o_over,
  output logic        o_busy
);
  logic [7:0] n_q;
  logic [7:0] ph_q;

  // code for sample k is base plus k, steady over the whole high phase
  assign o_code = i_base + {6'h0, n_q};
  assign o_over = i_over;

  // clock stands low between frames
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sample_clock <= 1'h0;
      o_busy         <= 1'h0;
      n_q            <= 8'h00;
      ph_q           <= 8'h00;
    end else if (i_start) begin
      o_busy <= 1'h1;
      n_q    <= 8'h00;
      ph_q   <= 8'h00;
    end else if (o_busy) begin
      ph_q <= (ph_q == 8'(2 * HALF - 1)) ? 8'h00 : ph_q + 8'h01;
      if (ph_q == 8'h00) begin
        if (n_q == i_edges) o_busy <= 1'h0;
        else o_sample_clock <= 1'h1;
      end
      if (ph_q == 8'(HALF)) begin
        o_sample_clock <= 1'h0;
        n_q            <= n_q + 8'h01;
      end
    end
  end
endmodule

// >>> dadc_ctrl.sv
// top of the dual converter output control: register slave, bus steering, interrupt
//
// How it works
// R1 - each channel samples on its own clock rising edge, channels independent
// R2 - swap select high: channel A on bus A, channel B on bus B
// R3 - swap select low: buses exchanged, A on bus B, B on bus A
// R4 - interleaving needs swap select and both clocks from one signal
// R5 - power down low, enable low: convert and drive outputs
// R6 - power down low, enable high: convert, outputs high impedance
// R7 - power down high, enable low: nap, outputs high impedance
// R8 - power down high, enable high: sleep, outputs high impedance
// R9 - mode selects offset binary or two's complement and stabiliser on or off
// R10 - format and stabiliser are one setting shared by both channels
// R11 - over-range flag high when input went beyond full scale either way
// R12 - result is 14 bits wide, bit 13 most significant
// R13 - result appears six sample clocks after its sample
// R14 - input tracked while clock low, frozen at rising edge
// R15 - word and flag update once per sample clock, stable between
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module dadc_ctrl
  import dadc_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // axi4-lite write address
  input  wire logic [11:0] i_s_axi_awaddr,
  input  wire logic [2:0]  i_s_axi_awprot,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] i_s_axi_araddr,
  input  wire logic [2:0]  i_s_axi_arprot,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  // channel a converter side
  input  wire logic        i_chan_a_sample_clock,
  input  wire logic [13:0] i_chan_a_conv_code,
  input  wire logic        i_chan_a_conv_over,
  // channel b converter side
  input  wire logic        i_chan_b_sample_clock,
  input  wire logic [13:0] i_chan_b_conv_code,
  input  wire logic        i_chan_b_conv_over,
  // output bus a
  output logic [13:0]      o_bus_a_data,
  output logic             o_bus_a_over_range,
  output logic             o_bus_a_oe,
  // output bus b
  output logic [13:0]      o_bus_b_data,
  output logic             o_bus_b_over_range,
  output logic             o_bus_b_oe,
  // shared settings and interrupt
  output logic             o_duty_stabiliser_en,
  output logic             o_irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]   ctrl_q;
  logic [7:0]   ctrl_d;
  logic [1:0]   mask_q;
  logic [1:0]   mask_d;
  logic [1:0]   irq_q;
  logic [1:0]   irq_d;

  logic         aw_got_q;
  logic [11:0]  aw_addr_q;
  logic         w_got_q;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;
  logic         bvalid_q;
  logic [1:0]   bresp_q;
  logic         rvalid_q;
  logic [31:0]  rdata_q;
  logic [1:0]   rresp_q;

  logic         aw_take_w;
  logic         w_take_w;
  logic         ar_take_w;
  logic         do_write_w;
  logic         wr_ctrl_w;
  logic         wr_mask_w;
  logic         wr_hit_w;
  logic         rd_hit_w;
  logic [31:0]  rd_data_w;
  logic         rd_clr_w;
  logic [1:0]   event_w;

  logic [1:0]   mode_w;
  logic         twos_w;
  logic         dcs_w;
  logic         swap_w;

  dadc_word_s   res_a_w;
  dadc_word_s   res_b_w;
  logic         stb_a_w;
  logic         stb_b_w;
  logic         drive_a_w;
  logic         drive_b_w;
  logic         clk_a_lvl_w;
  dadc_pwr_e    pwr_a_w;
  dadc_pwr_e    pwr_b_w;

  dadc_word_s   bus_a_d;
  dadc_word_s   bus_b_d;
  dadc_word_s   bus_a_q;
  dadc_word_s   bus_b_q;
  logic         bus_a_oe_q;
  logic         bus_b_oe_q;

  // ****************************************************************
  // shared format and stabiliser setting
  // ****************************************************************
  assign mode_w = ctrl_q[CTRL_MODE_LO +: 2];
  // one mode field feeds both channels, no per-channel override
  assign twos_w = mode_w[1]; // R9 R10
  assign dcs_w  = mode_w[1] ^ mode_w[0]; // R9 R10

  // ****************************************************************
  // channels
  // ****************************************************************
  dadc_chan u_chan_a (
    .i_ref_clk           (i_ref_clk),
    .i_rst_b             (i_rst_b),
    .i_sample_clock      (i_chan_a_sample_clock),
    .i_conv_code         (i_chan_a_conv_code),
    .i_conv_over         (i_chan_a_conv_over),
    .i_power_down_select (ctrl_q[CTRL_PD_A]),
    .i_output_enable_n   (ctrl_q[CTRL_OEN_A]),
    .i_twos              (twos_w),
    .o_res               (res_a_w),
    .o_res_stb           (stb_a_w),
    .o_drive             (drive_a_w),
    .o_clk_lvl           (clk_a_lvl_w),
    .o_pwr               (pwr_a_w)
  );

  dadc_chan u_chan_b (
    .i_ref_clk           (i_ref_clk),
    .i_rst_b             (i_rst_b),
    .i_sample_clock      (i_chan_b_sample_clock),
    .i_conv_code         (i_chan_b_conv_code),
    .i_conv_over         (i_chan_b_conv_over),
    .i_power_down_select (ctrl_q[CTRL_PD_B]),
    .i_output_enable_n   (ctrl_q[CTRL_OEN_B]),
    .i_twos              (twos_w),
    .o_res               (res_b_w),
    .o_res_stb           (stb_b_w),
    .o_drive             (drive_b_w),
    .o_clk_lvl           (),
    .o_pwr               (pwr_b_w)
  );

  // ****************************************************************
  // bus steering
  // ****************************************************************
  // interleave lets the channel a clock level act as the select;
  // only meaningful when both clocks share one source
  assign swap_w = ctrl_q[CTRL_ILEAVE] ? clk_a_lvl_w : ctrl_q[CTRL_SWAP]; // R4

  assign bus_a_d = swap_w ? res_a_w : res_b_w; // R2 R3
  assign bus_b_d = swap_w ? res_b_w : res_a_w; // R2 R3

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_a_q    <= '0;
      bus_b_q    <= '0;
      bus_a_oe_q <= 1'b0;
      bus_b_oe_q <= 1'b0;
    end else begin
      bus_a_q    <= bus_a_d; // R2 R3
      bus_b_q    <= bus_b_d; // R2 R3
      bus_a_oe_q <= swap_w ? drive_a_w : drive_b_w; // R5 R6 R7 R8
      bus_b_oe_q <= swap_w ? drive_b_w : drive_a_w; // R5 R6 R7 R8
    end
  end

  assign o_bus_a_data         = bus_a_q.data; // R12
  assign o_bus_a_over_range   = bus_a_q.over; // R11
  assign o_bus_a_oe           = bus_a_oe_q;
  assign o_bus_b_data         = bus_b_q.data; // R12
  assign o_bus_b_over_range   = bus_b_q.over; // R11
  assign o_bus_b_oe           = bus_b_oe_q;
  assign o_duty_stabiliser_en = dcs_w;

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  // address and data are held until both are in; no new beat is
  // taken while a response waits, so one write is open at a time
  assign o_s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign o_s_axi_wready  = ~w_got_q & ~bvalid_q;
  assign aw_take_w       = i_s_axi_awvalid & o_s_axi_awready;
  assign w_take_w        = i_s_axi_wvalid & o_s_axi_wready;
  assign do_write_w      = aw_got_q & w_got_q & ~bvalid_q;
  assign wr_ctrl_w       = do_write_w & (aw_addr_q == ADDR_CTRL);
  assign wr_mask_w       = do_write_w & (aw_addr_q == ADDR_IRQ_MASK);
  assign wr_hit_w        = (aw_addr_q == ADDR_CTRL) | (aw_addr_q == ADDR_IRQ_MASK);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_got_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_got_q   <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (aw_take_w) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= {i_s_axi_awaddr[11:2], 2'b00};
      end else if (do_write_w) begin
        aw_got_q  <= 1'b0;
      end
      if (w_take_w) begin
        w_got_q  <= 1'b1;
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
      end else if (do_write_w) begin
        w_got_q  <= 1'b0;
      end
      if (do_write_w) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit_w ? RESP_OKAY : RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp  = bresp_q;

  // ****************************************************************
  // control and mask registers
  // ****************************************************************
  // every field lives in byte lane 0, other lanes are ignored
  assign ctrl_d = (wr_ctrl_w & w_strb_q[0]) ? w_data_q[7:0] : ctrl_q;
  assign mask_d = (wr_mask_w & w_strb_q[0]) ? w_data_q[1:0] : mask_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= CTRL_RST;
      mask_q <= IRQ_MASK_RST;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
    end
  end

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  assign o_s_axi_arready = ~rvalid_q;
  assign ar_take_w       = i_s_axi_arvalid & o_s_axi_arready;

  assign rd_hit_w = (i_s_axi_araddr[11:2] == ADDR_CTRL[11:2])
                  | (i_s_axi_araddr[11:2] == ADDR_STATUS[11:2])
                  | (i_s_axi_araddr[11:2] == ADDR_IRQ_STAT[11:2])
                  | (i_s_axi_araddr[11:2] == ADDR_IRQ_MASK[11:2])
                  | (i_s_axi_araddr[11:2] == ADDR_DATA_A[11:2])
                  | (i_s_axi_araddr[11:2] == ADDR_DATA_B[11:2]);

  assign rd_data_w =
    (i_s_axi_araddr[11:2] == ADDR_CTRL[11:2])     ? {24'h000000, ctrl_q} :
    (i_s_axi_araddr[11:2] == ADDR_STATUS[11:2])   ? {26'h0000000, dcs_w, twos_w, pwr_b_w, pwr_a_w} :
    (i_s_axi_araddr[11:2] == ADDR_IRQ_STAT[11:2]) ? {30'h00000000, irq_q} :
    (i_s_axi_araddr[11:2] == ADDR_IRQ_MASK[11:2]) ? {30'h00000000, mask_q} :
    (i_s_axi_araddr[11:2] == ADDR_DATA_A[11:2])   ? {17'h00000, res_a_w} :
    (i_s_axi_araddr[11:2] == ADDR_DATA_B[11:2])   ? {17'h00000, res_b_w} :
                                                    32'h0000_0000;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else begin
      if (ar_take_w) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_data_w;
        rresp_q  <= rd_hit_w ? RESP_OKAY : RESP_SLVERR;
      end else if (i_s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata  = rdata_q;
  assign o_s_axi_rresp  = rresp_q;

  // ****************************************************************
  // interrupt
  // ****************************************************************
  // an over-range result arriving in the clearing cycle stays set
  assign rd_clr_w = ar_take_w & (i_s_axi_araddr[11:2] == ADDR_IRQ_STAT[11:2]);
  assign event_w  = {stb_b_w & res_b_w.over, stb_a_w & res_a_w.over}; // R11
  assign irq_d    = (irq_q & ~{IRQ_W{rd_clr_w}}) | event_w;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_q <= 2'h0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign o_irq = |(irq_q & mask_q);

endmodule

// >>> dadc_ctrl_chk.sv
// port assertions for the dual converter output control
`timescale 1ns/1ps
module dadc_ctrl_chk
  import dadc_pkg::*;
(
  // clock and reset
  input logic        i_ref_clk,
  input logic        i_rst_b,
  // register bus
  input logic        i_s_axi_awvalid,
  input logic        o_s_axi_awready,
  input logic        i_s_axi_wvalid,
  input logic        o_s_axi_wready,
  input logic [1:0]  o_s_axi_bresp,
  input logic        o_s_axi_bvalid,
  input logic        i_s_axi_bready,
  input logic        i_s_axi_arvalid,
  input logic        o_s_axi_arready,
  input logic [31:0] o_s_axi_rdata,
  input logic [1:0]  o_s_axi_rresp,
  input logic        o_s_axi_rvalid,
  input logic        i_s_axi_rready,
  // pins
  input logic        i_chan_a_sample_clock,
  input logic        i_chan_b_sample_clock,
  input logic [13:0] o_bus_a_data,
  input logic [13:0] o_bus_b_data,
  input logic        o_duty_stabiliser_en
);
  // ****
  // sequences
  // ****
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence

  // no sample edge and no register write for four cycles
  sequence s_quiet;
    (!i_chan_a_sample_clock && !i_chan_b_sample_clock && !o_s_axi_bvalid && !i_s_axi_awvalid) [*4];
  endsequence

  AST_WR_ANSWER: assert property (s_wr_taken |=> !o_s_axi_bvalid ##1 o_s_axi_bvalid)
    else $error("write answer late or early");
  AST_B_STANDS: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write answer dropped");
  AST_B_BLOCKS: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken during answer");
  AST_RD_ANSWER: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  AST_R_STANDS: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata) && $stable(o_s_axi_rresp))
    else $error("read answer dropped");
  AST_AR_READY: assert property (o_s_axi_arready == !o_s_axi_rvalid)
    else $error("read ready wrong");
  AST_R_ERR_ZERO: assert property (o_s_axi_rvalid && o_s_axi_rresp != RESP_OKAY |->
    o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0)
    else $error("bad error answer");
  AST_BUS_HOLD: assert property (s_quiet |=> $stable(o_bus_a_data) && $stable(o_bus_b_data))
    else $error("word moved without edge");
  AST_DCS_WRITE: assert property ($changed(o_duty_stabiliser_en) |-> o_s_axi_bvalid)
    else $error("stabiliser moved unwritten");
endmodule

bind dadc_ctrl dadc_ctrl_chk chk_u (.*);

// >>> dadc_pkg.sv
// constants, register map and shared types of the dual converter output control
package dadc_pkg;

  // ****************************************************************
  // converter geometry
  // ****************************************************************
  localparam int          DATA_W        = 14;
  localparam int          PIPE_LAT      = 6;
  localparam logic [13:0] TWOS_FLIP     = 14'h2000;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
  localparam logic [11:0] ADDR_DATA_A   = 12'h010;
  localparam logic [11:0] ADDR_DATA_B   = 12'h014;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int          CTRL_SWAP     = 0;
  localparam int          CTRL_ILEAVE   = 1;
  localparam int          CTRL_PD_A     = 2;
  localparam int          CTRL_OEN_A    = 3;
  localparam int          CTRL_PD_B     = 4;
  localparam int          CTRL_OEN_B    = 5;
  localparam int          CTRL_MODE_LO  = 6;
  localparam int          CTRL_W        = 8;
  localparam logic [7:0]  CTRL_RST      = 8'h01;

  // ****************************************************************
  // status, interrupt and data readback fields
  // ****************************************************************
  localparam int          STAT_PWR_A    = 0;
  localparam int          STAT_PWR_B    = 2;
  localparam int          STAT_TWOS     = 4;
  localparam int          STAT_DCS      = 5;
  localparam int          IRQ_W         = 2;
  localparam int          IRQ_OVR_A     = 0;
  localparam int          IRQ_OVR_B     = 1;
  localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;
  localparam int          DATA_OVR      = 14;

  // ****************************************************************
  // bus answers
  // ****************************************************************
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic              over;
    logic [13:0]       data;
  } dadc_word_s;

  typedef enum logic [1:0] {
    DADC_RUN,
    DADC_RUN_HIZ,
    DADC_NAP,
    DADC_SLEEP
  } dadc_pwr_e;

endpackage

// >>> tb_top.sv
// self-checking bench for the dual converter output control
`timescale 1ns/1ps
module tb_top;
  import dadc_pkg::*;
  logic i_ref_clk = 1'h0;
  logic i_rst_b = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, clk_a, clk_b, ov_a, ov_b, busy_a, busy_b;
  logic [1:0] bresp, rresp;
  logic [13:0] code_a, code_b, bus_a, bus_b;
  logic ovr_a, ovr_b, oe_a, oe_b, dcs, irq;
  logic start = 1'h0, over_a = 1'h0;
  logic [7:0] edges = 8'h00;
  logic [13:0] base_a = 14'h0, base_b = 14'h0;
  int failures = 0;
  int n_checks = 0;

  always #10 i_ref_clk = ~i_ref_clk;

  dadc_ctrl dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(3'h0), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arprot(3'h0), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_chan_a_sample_clock(clk_a), .i_chan_a_conv_code(code_a), .i_chan_a_conv_over(ov_a),
    .i_chan_b_sample_clock(clk_b), .i_chan_b_conv_code(code_b), .i_chan_b_conv_over(ov_b),
    .o_bus_a_data(bus_a), .o_bus_a_over_range(ovr_a), .o_bus_a_oe(oe_a),
    .o_bus_b_data(bus_b), .o_bus_b_over_range(ovr_b), .o_bus_b_oe(oe_b),
    .o_duty_stabiliser_en(dcs), .o_irq(irq));
  // channel b runs a slower clock so the two channels' rising edges coincide only at the frame start and every 40 reference cycles
  dadc_conv_model #(.HALF(4)) pa_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_start(start),
    .i_edges(edges), .i_base(base_a), .i_over(over_a), .o_sample_clock(clk_a), .o_code(code_a),
    .o_over(ov_a), .o_busy(busy_a));
  dadc_conv_model #(.HALF(5)) pb_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_start(start),
    .i_edges(edges), .i_base(base_b), .i_over(~over_a), .o_sample_clock(clk_b), .o_code(code_b),
    .o_over(ov_b), .o_busy(busy_b));

  // ****
  // shared tasks
  // ****
  task automatic test_done;
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tmo;
    failures++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    test_done();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    int k;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge i_ref_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'h1;
    end
    if (k == 50) tmo();
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [31:0] exp);
    int k;
    araddr <= a;
    arvalid <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge i_ref_clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'h1;
    end
    if (k == 50) tmo();
    rready <= 1'h0;
    chk({30'h0, rresp}, {30'h0, er});
    chk(rdata, exp);
  endtask

  task automatic run(input logic [7:0] n, input logic [13:0] ba, input logic [13:0] bb, input logic oa);
    int k;
    edges <= n;
    base_a <= ba;
    base_b <= bb;
    over_a <= oa;
    start <= 1'h1;
    @(posedge i_ref_clk);
    start <= 1'h0;
    for (k = 0; k < 400; k++) begin
      @(posedge i_ref_clk);
      if (!busy_a && !busy_b) break;
    end
    if (k == 400) tmo();
    repeat (4) @(posedge i_ref_clk);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_regs;
    rd(ADDR_CTRL, RESP_OKAY, 32'h01);
    rd(ADDR_IRQ_MASK, RESP_OKAY, 32'h0);
    rd(12'h100, RESP_SLVERR, 32'h0);
    wr(12'h100, 32'hFF, RESP_SLVERR);
    rd(ADDR_CTRL, RESP_OKAY, 32'h01);
  endtask

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, 32'h01 | (m << 6), RESP_OKAY);
      chk({31'h0, dcs}, (m == 1 || m == 2));
      rd(ADDR_STATUS, RESP_OKAY, {26'h0, 1'(m == 1 || m == 2), 1'(m >> 1), 4'h0});
    end
  endtask

  // last shown word after n edges is the sample taken six edges earlier
  task automatic t_stream;
    wr(ADDR_CTRL, 32'h01, RESP_OKAY);
    run(8'h0A, 14'h1000, 14'h0800, 1'h0);
    chk(bus_a, 14'h1003);
    chk(bus_b, 14'h0803);
    chk({oe_a, oe_b}, 2'h3);
    wr(ADDR_CTRL, 32'h81, RESP_OKAY);
    run(8'h0A, 14'h1000, 14'h0800, 1'h0);
    chk(bus_a, 14'h3003);
    chk(bus_b, 14'h2803);
    wr(ADDR_CTRL, 32'h00, RESP_OKAY);
    run(8'h08, 14'h0123, 14'h3210, 1'h0);
    chk(bus_a, 14'h3211);
    chk(bus_b, 14'h0124);
    wr(ADDR_CTRL, 32'h03, RESP_OKAY);
    chk(bus_a, 14'h3211);
  endtask

  task automatic t_power;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, 32'h01 | ((i >> 1) * 32'h14) | ((i & 1) * 32'h28), RESP_OKAY);
      chk({oe_a, oe_b}, (i == 0) ? 2'h3 : 2'h0);
      rd(ADDR_STATUS, RESP_OKAY, 32'h0 | (i * 5));
    end
    wr(ADDR_CTRL, 32'h29, RESP_OKAY);
    run(8'h07, 14'h0555, 14'h0AAA, 1'h0);
    chk({oe_a, bus_a}, {1'h0, 14'h0555});
    wr(ADDR_CTRL, 32'h3D, RESP_OKAY);
    wr(ADDR_CTRL, 32'h01, RESP_OKAY);
    run(8'h06, 14'h0555, 14'h0AAA, 1'h0);
    chk(bus_a, 14'h0);
  endtask

  task automatic t_irq;
    wr(ADDR_CTRL, 32'h01, RESP_OKAY);
    wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
    run(8'h08, 14'h3FF0, 14'h0001, 1'h1);
    chk({ovr_a, ovr_b, irq}, 3'h4);
    wr(ADDR_IRQ_MASK, 32'h3, RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_DATA_A, RESP_OKAY, 32'h7FF1);
    rd(ADDR_IRQ_STAT, RESP_OKAY, 32'h3);
    chk({31'h0, irq}, 32'h0);
    rd(ADDR_IRQ_STAT, RESP_OKAY, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_rst_b <= 1'h1;
    @(posedge i_ref_clk);
    t_regs();
    t_modes();
    t_stream();
    t_power();
    t_irq();
    test_done();
  end
endmodule
